// >>> design/pic_top.sv
// port pin interrupt control with ahb-lite register slave
//
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "pic_regs.svh"
module pic_top
   import pic_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire pic_pins_type pins,
   input wire logic bus_resume,
   output logic port0_irq,
   output logic port1_irq,
   output logic port2_irq,
   output logic irq
);

   // ---------------------------------------------------------------
   // input synchronisers and edge detection
   // ---------------------------------------------------------------
   pic_pins_type sync1_q;
   pic_pins_type sync2_q;
   pic_pins_type prev_q;
   pic_pins_type in_now;
   pic_pins_type rise;
   pic_pins_type fall;
   pic_pins_type edge_hit;
   logic resume1_q;
   logic resume2_q;

   // first stage is read only by the second
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_q <= '0;
         sync2_q <= '0;
         resume1_q <= 1'b0;
         resume2_q <= 1'b0;
      end else begin
         sync1_q <= pins;
         sync2_q <= sync1_q;
         resume1_q <= bus_resume;
         resume2_q <= resume1_q;
      end
   end

   always_comb begin
      in_now = sync2_q;
      // resume shares bit 7 with the pin, so either raises it
      in_now.port0[`PIC_BIT_RESUME] = sync2_q.port0[`PIC_BIT_RESUME] |
         resume2_q;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prev_q <= '0;
      end else begin
         prev_q <= in_now;
      end
   end

   logic [7:0] ctl_q;

   always_comb begin
      rise = in_now & ~prev_q;
      fall = ~in_now & prev_q;
      edge_hit.port0 = ctl_q[`PIC_BIT_P0_EDGE] ? fall.port0
         : rise.port0;
      edge_hit.port1 = ctl_q[`PIC_BIT_P1_EDGE] ? fall.port1
         : rise.port1;
      edge_hit.port2 = ctl_q[`PIC_BIT_P2_EDGE] ? fall.port2
         : rise.port2;
   end

   // ---------------------------------------------------------------
   // ahb-lite slave, always zero wait states
   // ---------------------------------------------------------------
   pic_req_type req_q;
   logic wr_en;
   logic rd_sel;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         req_q <= '0;
      end else if (hready) begin
         req_q.valid <= hsel & htrans[1];
         req_q.write <= hwrite;
         req_q.addr <= haddr[`PIC_ADDR_BITS+`PIC_ADDR_LSB-1:`PIC_ADDR_LSB];
      end
   end

   assign wr_en = req_q.valid & req_q.write;
   assign rd_sel = hsel & htrans[1] & ~hwrite & hready;

   logic [7:0] p0_flags_q;
   logic [7:0] p1_flags_q;
   logic [4:0] p2_flags_q;
   logic [7:0] p1_mask_q;
   logic [2:0] irq_st_q;
   logic [2:0] irq_mask_q;
   logic [2:0] req_lvl;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctl_q <= `PIC_CTL_RESET;
         p1_mask_q <= `PIC_MASK_RESET;
         irq_mask_q <= `PIC_IRQ_RESET;
      end else if (wr_en) begin
         if (req_q.addr == `PIC_ADDR_CONTROL) begin
            ctl_q <= hwdata[7:0] & `PIC_CTL_WMASK;
         end
         if (req_q.addr == `PIC_ADDR_P1_MASK) begin
            p1_mask_q <= hwdata[7:0];
         end
         if (req_q.addr == `PIC_ADDR_IRQ_MASK) begin
            irq_mask_q <= hwdata[2:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // pending flags: write zero clears, a new edge wins over the clear
   // ---------------------------------------------------------------
   logic [7:0] p0_keep;
   logic [7:0] p1_keep;
   logic [4:0] p2_keep;

   always_comb begin
      p0_keep = 8'hff;
      p1_keep = 8'hff;
      p2_keep = 5'h1f;
      if (wr_en && req_q.addr == `PIC_ADDR_P0_FLAGS) begin
         p0_keep = hwdata[7:0];
      end
      if (wr_en && req_q.addr == `PIC_ADDR_P1_FLAGS) begin
         p1_keep = hwdata[7:0];
      end
      if (wr_en && req_q.addr == `PIC_ADDR_P2_FLAGS) begin
         p2_keep = hwdata[`PIC_P2_WIDTH-1:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         p0_flags_q <= `PIC_FLAGS_RESET;
         p1_flags_q <= `PIC_FLAGS_RESET;
         p2_flags_q <= '0;
      end else begin
         p0_flags_q <= (p0_flags_q & p0_keep) | edge_hit.port0;
         p1_flags_q <= (p1_flags_q & p1_keep) | edge_hit.port1;
         p2_flags_q <= (p2_flags_q & p2_keep) | edge_hit.port2;
      end
   end

   // ---------------------------------------------------------------
   // group gating towards the cpu
   // ---------------------------------------------------------------
   always_comb begin
      req_lvl[`PIC_IRQ_P0] =
         (|p0_flags_q[7:4] & ctl_q[`PIC_BIT_P0H_EN]) |
         (|p0_flags_q[3:0] & ctl_q[`PIC_BIT_P0L_EN]);
      req_lvl[`PIC_IRQ_P1] = |(p1_flags_q & p1_mask_q);
      req_lvl[`PIC_IRQ_P2] = |p2_flags_q & ctl_q[`PIC_BIT_P2_EN];
   end

   // sticky status, write one to clear; a new request wins
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_st_q <= `PIC_IRQ_RESET;
      end else if (wr_en && req_q.addr == `PIC_ADDR_IRQ_STATUS) begin
         irq_st_q <= (irq_st_q & ~hwdata[2:0]) | req_lvl;
      end else begin
         irq_st_q <= irq_st_q | req_lvl;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         port0_irq <= 1'b0;
         port1_irq <= 1'b0;
         port2_irq <= 1'b0;
         irq <= 1'b0;
      end else begin
         port0_irq <= req_lvl[`PIC_IRQ_P0];
         port1_irq <= req_lvl[`PIC_IRQ_P1];
         port2_irq <= req_lvl[`PIC_IRQ_P2];
         irq <= |(irq_st_q & irq_mask_q);
      end
   end

   // ---------------------------------------------------------------
   // read data, registered in the address phase to keep outputs flopped
   // ---------------------------------------------------------------
   logic [31:0] rd_d;

   always_comb begin
      rd_d = 32'h0000_0000;
      unique case (haddr[`PIC_ADDR_BITS+`PIC_ADDR_LSB-1:`PIC_ADDR_LSB])
         `PIC_ADDR_P0_FLAGS: rd_d[7:0] = p0_flags_q;
         `PIC_ADDR_P1_FLAGS: rd_d[7:0] = p1_flags_q;
         `PIC_ADDR_P2_FLAGS: rd_d[4:0] = p2_flags_q;
         `PIC_ADDR_CONTROL: rd_d[7:0] = ctl_q;
         `PIC_ADDR_P1_MASK: rd_d[7:0] = p1_mask_q;
         `PIC_ADDR_IRQ_STATUS: rd_d[2:0] = irq_st_q;
         `PIC_ADDR_IRQ_MASK: rd_d[2:0] = irq_mask_q;
         default: rd_d = 32'h0000_0000;
      endcase
   end

   // limitation: a read right after a write to the same word sees old data
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hrdata <= rd_sel ? rd_d : 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   property p_p2_gate;
      @(posedge hclk) disable iff (!hresetn)
      !ctl_q[`PIC_BIT_P2_EN] |=> !port2_irq;
   endproperty
   a_p2_gate: assert property (p_p2_gate)
      else $error("port 2 request passed while disabled");

   property p_p0h_gate;
      @(posedge hclk) disable iff (!hresetn)
      (|p0_flags_q[7:4] && ctl_q[`PIC_BIT_P0H_EN]) |=> port0_irq;
   endproperty
   a_p0h_gate: assert property (p_p0h_gate)
      else $error("port 0 upper request not passed");

   property p_p0l_gate;
      @(posedge hclk) disable iff (!hresetn)
      (!ctl_q[`PIC_BIT_P0L_EN] &&
       !(|p0_flags_q[7:4] && ctl_q[`PIC_BIT_P0H_EN])) |=> !port0_irq;
   endproperty
   a_p0l_gate: assert property (p_p0l_gate)
      else $error("port 0 request passed while disabled");

   property p_p2_edge;
      @(posedge hclk) disable iff (!hresetn)
      (ctl_q[`PIC_BIT_P2_EDGE] && in_now.port2[0] && !prev_q.port2[0] &&
       !p2_flags_q[0]) |=> !p2_flags_q[0];
   endproperty
   a_p2_edge: assert property (p_p2_edge)
      else $error("port 2 rising edge flagged in falling mode");

   property p_p1_edge;
      @(posedge hclk) disable iff (!hresetn)
      (!ctl_q[`PIC_BIT_P1_EDGE] && sync2_q.port1[0] && !prev_q.port1[0])
      |=> p1_flags_q[0];
   endproperty
   a_p1_edge: assert property (p_p1_edge)
      else $error("port 1 rising edge not flagged");

   property p_p0_edge;
      @(posedge hclk) disable iff (!hresetn)
      (ctl_q[`PIC_BIT_P0_EDGE] && !in_now.port0[0] && prev_q.port0[0])
      |=> p0_flags_q[0];
   endproperty
   a_p0_edge: assert property (p_p0_edge)
      else $error("port 0 falling edge not flagged");

   property p_resume;
      @(posedge hclk) disable iff (!hresetn)
      (!ctl_q[`PIC_BIT_P0_EDGE] && resume2_q && !prev_q.port0[7])
      |=> p0_flags_q[7];
   endproperty
   a_resume: assert property (p_resume)
      else $error("resume event not flagged on port 0 bit 7");

   property p_clear;
      @(posedge hclk) disable iff (!hresetn)
      (wr_en && req_q.addr == `PIC_ADDR_P1_FLAGS && !hwdata[0] &&
       !edge_hit.port1[0]) |=> !p1_flags_q[0];
   endproperty
   a_clear: assert property (p_clear)
      else $error("pending flag not cleared by zero write");

   property p_mask;
      @(posedge hclk) disable iff (!hresetn)
      (p1_mask_q == 8'h00) |=> !port1_irq;
   endproperty
   a_mask: assert property (p_mask)
      else $error("port 1 request passed while masked");

   property p_sample;
      @(posedge hclk) disable iff (!hresetn)
      (prev_q.port1[1] == $past(in_now.port1[1])) || $rose(hresetn);
   endproperty
   a_sample: assert property (p_sample)
      else $error("previous sample not kept");

   property p_p2_open;
      @(posedge hclk) disable iff (!hresetn)
      (|p2_flags_q && ctl_q[`PIC_BIT_P2_EN]) |=> port2_irq;
   endproperty
   a_p2_open: assert property (p_p2_open)
      else $error("port 2 request not passed while enabled");

   property p_p0l_open;
      @(posedge hclk) disable iff (!hresetn)
      (|p0_flags_q[3:0] && ctl_q[`PIC_BIT_P0L_EN]) |=> port0_irq;
   endproperty
   a_p0l_open: assert property (p_p0l_open)
      else $error("port 0 lower request not passed");

   property p_p1_open;
      @(posedge hclk) disable iff (!hresetn)
      (|(p1_flags_q & p1_mask_q)) |=> port1_irq;
   endproperty
   a_p1_open: assert property (p_p1_open)
      else $error("port 1 unmasked request not passed");

   // a rising edge in falling mode must leave a clear flag alone
   property p_p1_rise_block;
      @(posedge hclk) disable iff (!hresetn)
      (ctl_q[`PIC_BIT_P1_EDGE] && in_now.port1[0] && !prev_q.port1[0] &&
       !p1_flags_q[0]) |=> !p1_flags_q[0];
   endproperty
   a_p1_rise_block: assert property (p_p1_rise_block)
      else $error("port 1 rising edge flagged in falling mode");

   c_p0_irq: cover property (@(posedge hclk) disable iff (!hresetn)
      $rose(port0_irq));
   c_p2_irq: cover property (@(posedge hclk) disable iff (!hresetn)
      $rose(port2_irq));
   c_irq: cover property (@(posedge hclk) disable iff (!hresetn)
      $rose(irq));
   c_resume: cover property (@(posedge hclk) disable iff (!hresetn)
      $rose(p0_flags_q[`PIC_BIT_RESUME]));

endmodule : pic_top

// >>> design/pic_regs.svh
// register map, field positions and reset values of the port interrupt block
// Summary of operation
// - port 2 inputs 4..0 reach the cpu only while bit 5 is one
// - port 0 inputs 7..4 reach the cpu only while bit 4 is one
// - port 0 inputs 3..0 reach the cpu only while bit 3 is one
// - bit 2 picks rising (0) or falling (1) edge for port 2
// - bit 1 picks rising (0) or falling (1) edge for port 1
// - bit 0 picks rising (0) or falling (1) edge for port 0
// - internal bus-resume event enters as port 0 bit 7, on the edge that bit 0 picks
// - each input has a pending flag, one when pending, cleared by writing zero
// - port 1 pins are gated one by one through an 8-bit mask
`ifndef PIC_REGS_SVH
`define PIC_REGS_SVH
`define PIC_ADDR_P0_FLAGS 8'h89
`define PIC_ADDR_P1_FLAGS 8'h8a
`define PIC_ADDR_P2_FLAGS 8'h8b
`define PIC_ADDR_CONTROL 8'h8c
`define PIC_ADDR_P1_MASK 8'h8d
`define PIC_ADDR_IRQ_STATUS 8'h90
`define PIC_ADDR_IRQ_MASK 8'h94
// offsets above are word indices; the bus byte address is four times one
`define PIC_ADDR_BITS 8
`define PIC_ADDR_LSB 2
`define PIC_CTL_RESET 8'h00
`define PIC_CTL_WMASK 8'h7f
`define PIC_BIT_P2_EN 5
`define PIC_BIT_P0H_EN 4
`define PIC_BIT_P0L_EN 3
`define PIC_BIT_P2_EDGE 2
`define PIC_BIT_P1_EDGE 1
`define PIC_BIT_P0_EDGE 0
`define PIC_BIT_RESUME 7
`define PIC_P2_WIDTH 5
`define PIC_FLAGS_RESET 8'h00
`define PIC_MASK_RESET 8'h00
`define PIC_IRQ_RESET 3'h0
`define PIC_IRQ_BITS 3
`define PIC_IRQ_P0 0
`define PIC_IRQ_P1 1
`define PIC_IRQ_P2 2
`endif

// >>> design/pic_pkg.sv
// types shared by the port interrupt block
package pic_pkg;
   typedef struct packed {
      logic [7:0] port0;
      logic [7:0] port1;
      logic [4:0] port2;
   } pic_pins_type;

   typedef struct packed {
      logic [7:0] addr;
      logic write;
      logic valid;
   } pic_req_type;
endpackage : pic_pkg

// >>> verification/pic_pin_model.sv
// behavioural pin and resume source facing the port interrupt block
`timescale 1ns/1ps
module pic_pin_model
   import pic_pkg::*;
(
   input wire logic hclk,
   output pic_pins_type pins,
   output logic bus_resume
);
   // ----------------------------------------
   // pin drive
   // ----------------------------------------
   initial begin
      pins = '0;
      bus_resume = 1'b0;
   end

   // levels move only after an edge so the sampling side sees clean steps
   task automatic drive(input int p, input logic [7:0] v);
      @(posedge hclk);
      case (p)
         0: pins.port0 <= v;
         1: pins.port1 <= v;
         default: pins.port2 <= v[4:0];
      endcase
   endtask : drive

   // resume rises, is held four clocks, long enough for the two-stage sync, then falls
   task automatic resume_pulse();
      @(posedge hclk);
      bus_resume <= 1'b1;
      repeat (4) @(posedge hclk);
      bus_resume <= 1'b0;
   endtask : resume_pulse
endmodule : pic_pin_model

// >>> verification/test_pic_top.sv
// self-checking bench for the port interrupt block
`timescale 1ns/1ps
`include "pic_regs.svh"
module test_pic_top
   import pic_pkg::*;
;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic port0_irq;
   logic port1_irq;
   logic port2_irq;
   logic irq;
   pic_pins_type pins;
   logic bus_resume;
   int n_fail = 0;
   int check_count = 0;
   wire logic [2:0] grp = {port2_irq, port1_irq, port0_irq};

   always #4 hclk = ~hclk;

   pic_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .pins(pins), .bus_resume(bus_resume),
      .port0_irq(port0_irq), .port1_irq(port1_irq), .port2_irq(port2_irq),
      .irq(irq));

   pic_pin_model pm (.hclk(hclk), .pins(pins), .bus_resume(bus_resume));

   // ----------------------------------------
   // bus and compare tasks
   // ----------------------------------------
   task automatic check(input string n, input logic [31:0] e,
                        input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", n, e, g);
         n_fail++;
      end
   endtask : check

   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {22'h0, a, 2'h0};
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask : wr

   task automatic rd(input string n, input logic [7:0] a,
                     input logic [31:0] e);
      logic [31:0] x;
      bus(1'b0, a, 32'h0, x);
      check(n, e, x);
      check("response", 32'h0, {31'h0, hresp});
   endtask : rd

   task automatic clear_flags();
      for (int i = 0; i < 3; i++) wr(8'h89 + i[7:0], 32'h0);
   endtask : clear_flags

   // the edge bit of port p is control bit p, so idle level follows it
   task automatic edge_case(input int p, input logic [7:0] ctl,
      input logic [7:0] m1, input logic [7:0] bits, input logic e);
      logic [7:0] idle;
      idle = ctl[p] ? 8'hff : 8'h00;
      wr(`PIC_ADDR_CONTROL, {24'h0, ctl});
      wr(`PIC_ADDR_P1_MASK, {24'h0, m1});
      for (int i = 0; i < 3; i++) pm.drive(i, idle);
      repeat (5) @(posedge hclk);
      clear_flags();
      pm.drive(p, idle ^ bits);
      repeat (5) @(posedge hclk);
      rd("flags", 8'h89 + p[7:0], {24'h0, bits});
      check("group irq", {31'h0, e}, {31'h0, grp[p]});
      clear_flags();
      pm.drive(p, idle);
      repeat (5) @(posedge hclk);
      rd("flags back", 8'h89 + p[7:0], 32'h0);
   endtask : edge_case

   task automatic end_of_test();
      if (n_fail == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : end_of_test

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      #160000;
      n_fail++;
      end_of_test();
   end

   initial begin
      logic [7:0] regs [7];
      regs = '{8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'h90, 8'h94};
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      foreach (regs[i]) rd("reset", regs[i], 32'h0);
      wr(`PIC_ADDR_CONTROL, 32'hff);
      rd("control", `PIC_ADDR_CONTROL, 32'h7f);
      wr(8'h80, 32'hff);
      rd("unmapped", 8'h80, 32'h0);
      edge_case(0, 8'h18, 8'h00, 8'h01, 1'b1);
      edge_case(0, 8'h19, 8'h00, 8'h80, 1'b1);
      edge_case(0, 8'h10, 8'h00, 8'h0f, 1'b0);
      edge_case(0, 8'h08, 8'h00, 8'hf0, 1'b0);
      edge_case(0, 8'h10, 8'h00, 8'h10, 1'b1);
      edge_case(2, 8'h20, 8'h00, 8'h10, 1'b1);
      edge_case(2, 8'h24, 8'h00, 8'h01, 1'b1);
      edge_case(2, 8'h00, 8'h00, 8'h1f, 1'b0);
      edge_case(1, 8'h00, 8'hff, 8'h80, 1'b1);
      edge_case(1, 8'h02, 8'hff, 8'h01, 1'b1);
      edge_case(1, 8'h00, 8'h7f, 8'h80, 1'b0);
      // resume needs rising detection on port 0
      wr(`PIC_ADDR_CONTROL, 32'h10);
      clear_flags();
      wr(`PIC_ADDR_IRQ_STATUS, 32'h7);
      pm.resume_pulse();
      repeat (5) @(posedge hclk);
      rd("resume flag", `PIC_ADDR_P0_FLAGS, 32'h80);
      check("resume irq", 32'h1, {31'h0, port0_irq});
      rd("status", `PIC_ADDR_IRQ_STATUS, 32'h1);
      check("irq masked", 32'h0, {31'h0, irq});
      wr(`PIC_ADDR_IRQ_MASK, 32'h1);
      repeat (3) @(posedge hclk);
      check("irq unmasked", 32'h1, {31'h0, irq});
      clear_flags();
      repeat (4) @(posedge hclk);
      wr(`PIC_ADDR_IRQ_STATUS, 32'h7);
      rd("status clr", `PIC_ADDR_IRQ_STATUS, 32'h0);
      repeat (3) @(posedge hclk);
      check("irq clr", 32'h0, {31'h0, irq});
      end_of_test();
   end
endmodule : test_pic_top
